//--- arto_map.svh
// register map, field positions, reset values and counts of the timer
`ifndef ARTO_MAP_SVH
`define ARTO_MAP_SVH
`define ARTO_OFF_CTRL 8'h00
`define ARTO_OFF_CNT_LO 8'h04
`define ARTO_OFF_CNT_HI 8'h08
`define ARTO_OFF_RL_LO 8'h0c
`define ARTO_OFF_RL_HI 8'h10
`define ARTO_OFF_AUX 8'h14
`define ARTO_OFF_STAT 8'h18
`define ARTO_CTRL_FH 7
`define ARTO_CTRL_FL 6
`define ARTO_CTRL_LEN 5
`define ARTO_CTRL_CEN 4
`define ARTO_CTRL_SPLIT 3
`define ARTO_CTRL_RUN 2
`define ARTO_CTRL_XCLK_HI 1
`define ARTO_CTRL_XCLK_LO 0
`define ARTO_AUX_IE 0
`define ARTO_AUX_SYSH 1
`define ARTO_AUX_SYSL 2
`define ARTO_AUX_LFO1 3
`define ARTO_STAT_SYNC 0
`define ARTO_STAT_SUSP 1
`define ARTO_XCLK_SYS12 2'h0
`define ARTO_XCLK_EXT8 2'h1
`define ARTO_XCLK_RSVD 2'h2
`define ARTO_XCLK_LFO8 2'h3
`define ARTO_BYTE_RST 8'h00
`define ARTO_BYTE_MAX 8'hff
`define ARTO_SYNC_LAST 2'h2
`define ARTO_DIV_SYS 12
`define ARTO_DIV_OSC 8
`endif

//--- arto_pkg.sv
// state types of the auto-reload timer
package arto_pkg;
  typedef struct packed {
    logic [1:0] ext_sy;
    logic [1:0] lfo_sy;
    logic ext_d;
    logic lfo_d;
    logic [3:0] sys_cnt;
    logic [3:0] ext_cnt;
    logic [3:0] lfo_cnt;
    logic tick_sys12;
    logic tick_ext8;
    logic tick_lfo8;
    logic lfo_fall;
  } arto_tick_state_t;

  typedef struct packed {
    logic fh, fl, len, cen, split, run;
    logic [1:0] xclk;
    logic ie, sysh, sysl, lfo_div1;
    logic [7:0] cnt_lo, cnt_hi, rl_lo, rl_hi;
    logic sync_pend;
    logic [1:0] sync_cnt;
    logic susp_d, woke;
    logic [31:0] prdata;
    logic pready, pslverr, irq, wake;
  } arto_state_t;
endpackage

//--- arto_tick_if.sv
// timer clock ticks passed from the tick generator to the counter
`timescale 1ns/1ps
interface arto_tick_if;
  logic tick_sys12;
  logic tick_ext8;
  logic tick_lfo8;
  logic lfo_fall;
  modport src (
    output tick_sys12,
    output tick_ext8,
    output tick_lfo8,
    output lfo_fall
  );
  modport dst (
    input tick_sys12,
    input tick_ext8,
    input tick_lfo8,
    input lfo_fall
  );
endinterface

//--- arto_tick_gen.sv
// synchronises the slow clocks and divides them into one-cycle ticks
`timescale 1ns/1ps
`include "arto_map.svh"
module arto_tick_gen import arto_pkg::*; #(
  parameter int SYS_DIV = `ARTO_DIV_SYS,
  parameter int OSC_DIV = `ARTO_DIV_OSC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_osc_clk,
  input wire logic low_freq_oscillator,
  arto_tick_if.src tk
);
  arto_tick_state_t s_r, s_nxt;
  logic ext_rise, lfo_rise;

  // edges are taken from the second stage only
  assign ext_rise = s_r.ext_sy[1] & ~s_r.ext_d;
  assign lfo_rise = s_r.lfo_sy[1] & ~s_r.lfo_d;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ext_sy = {s_r.ext_sy[0], ext_osc_clk};
    s_nxt.lfo_sy = {s_r.lfo_sy[0], low_freq_oscillator};
    s_nxt.ext_d = s_r.ext_sy[1];
    s_nxt.lfo_d = s_r.lfo_sy[1];
    s_nxt.lfo_fall = s_r.lfo_d & ~s_r.lfo_sy[1];
    s_nxt.tick_sys12 = (s_r.sys_cnt == 4'(SYS_DIV - 1));
    s_nxt.sys_cnt = s_nxt.tick_sys12 ? 4'h0 : s_r.sys_cnt + 4'h1;
    s_nxt.tick_ext8 = ext_rise && (s_r.ext_cnt == 4'(OSC_DIV - 1));
    s_nxt.tick_lfo8 = lfo_rise && (s_r.lfo_cnt == 4'(OSC_DIV - 1));
    if (ext_rise)
      s_nxt.ext_cnt = s_nxt.tick_ext8 ? 4'h0 : s_r.ext_cnt + 4'h1;
    if (lfo_rise)
      s_nxt.lfo_cnt = s_nxt.tick_lfo8 ? 4'h0 : s_r.lfo_cnt + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tk.tick_sys12 = s_r.tick_sys12;
  assign tk.tick_ext8 = s_r.tick_ext8;
  assign tk.tick_lfo8 = s_r.tick_lfo8;
  assign tk.lfo_fall = s_r.lfo_fall;
endmodule // arto_tick_gen

//--- arto_timer.sv
// auto-reload timer with split mode, oscillator capture and apb registers
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "arto_map.svh"
module arto_timer import arto_pkg::*; #(
  parameter int SYS_DIV = `ARTO_DIV_SYS,
  parameter int OSC_DIV = `ARTO_DIV_OSC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_osc_clk,
  input wire logic low_freq_oscillator,
  input wire logic suspend,
  output logic irq_req,
  output logic wake_req,
  output logic sync_pending_status
);
  arto_tick_if tk ();
  arto_state_t s_r, s_nxt;

  arto_tick_gen #(
    .SYS_DIV(SYS_DIV),
    .OSC_DIV(OSC_DIV)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ext_osc_clk(ext_osc_clk),
    .low_freq_oscillator(low_freq_oscillator),
    .tk(tk.src)
  );

  // the low-frequency oscillator/8 source is dead unless its divider is one
  function automatic logic pick_tick(
    input logic sys_sel,
    input logic [1:0] xclk,
    input logic lfo_ok,
    input logic t12,
    input logic te8,
    input logic tl8
  );
    logic t;
    t = 1'b0;
    if (sys_sel)
      t = 1'b1;
    else
    begin
      unique case (xclk)
        `ARTO_XCLK_SYS12: t = t12;
        `ARTO_XCLK_EXT8: t = te8;
        `ARTO_XCLK_RSVD: t = 1'b0;
        `ARTO_XCLK_LFO8: t = tl8 & lfo_ok;
      endcase
    end
    return t;
  endfunction

  logic tick_lo, tick_hi;
  logic setup, access, wr, rd;

  // 16-bit mode and capture use the low byte's clock choice
  assign tick_lo = pick_tick(s_r.sysl, s_r.xclk, s_r.lfo_div1,
    tk.tick_sys12, tk.tick_ext8, tk.tick_lfo8);
  assign tick_hi = pick_tick(s_r.sysh, s_r.xclk, s_r.lfo_div1,
    tk.tick_sys12, tk.tick_ext8, tk.tick_lfo8);
  assign setup = psel & ~penable;
  assign access = psel & penable & s_r.pready;
  assign wr = access & pwrite;
  assign rd = setup & ~pwrite;

  always_comb
  begin
    logic set_fh, set_fl, ovf, run_lo, run_hi;
    logic [15:0] cnt16;
    logic [7:0] rdb;
    logic hit;
    set_fh = 1'b0;
    set_fl = 1'b0;
    ovf = 1'b0;
    run_lo = 1'b0;
    run_hi = 1'b0;
    cnt16 = {s_r.cnt_hi, s_r.cnt_lo};
    rdb = `ARTO_BYTE_RST;
    hit = 1'b1;
    s_nxt = s_r;

    // counting; the same synchronised ticks serve in and out of suspend
    if (!s_r.split)
    begin
      run_lo = s_r.run;
      if (run_lo && tick_lo)
      begin
        if (s_r.cnt_lo == `ARTO_BYTE_MAX)
          set_fl = 1'b1;
        if (cnt16 == {`ARTO_BYTE_MAX, `ARTO_BYTE_MAX})
        begin
          ovf = 1'b1;
          if (s_r.cen)
          begin
            // capture mode free-runs: a reload would spoil the measurement
            s_nxt.cnt_lo = `ARTO_BYTE_RST;
            s_nxt.cnt_hi = `ARTO_BYTE_RST;
          end
          else
          begin
            s_nxt.cnt_lo = s_r.rl_lo;
            s_nxt.cnt_hi = s_r.rl_hi;
            set_fh = 1'b1;
          end
        end
        else
        begin
          cnt16 = cnt16 + 16'h0001;
          s_nxt.cnt_lo = cnt16[7:0];
          s_nxt.cnt_hi = cnt16[15:8];
        end
      end
    end
    else
    begin
      run_lo = 1'b1;
      run_hi = s_r.run;
      if (run_lo && tick_lo)
      begin
        if (s_r.cnt_lo == `ARTO_BYTE_MAX)
        begin
          s_nxt.cnt_lo = s_r.rl_lo;
          set_fl = 1'b1;
          ovf = 1'b1;
        end
        else
          s_nxt.cnt_lo = s_r.cnt_lo + 8'h01;
      end
      if (run_hi && tick_hi)
      begin
        if (s_r.cnt_hi == `ARTO_BYTE_MAX)
        begin
          s_nxt.cnt_hi = s_r.rl_hi;
          set_fh = 1'b1;
          ovf = 1'b1;
        end
        else
          s_nxt.cnt_hi = s_r.cnt_hi + 8'h01;
      end
    end

    // apb: registered ready gives one access cycle, no wait states
    s_nxt.pready = 1'b0;
    if (setup)
    begin
      s_nxt.pready = 1'b1;
      unique case (paddr)
        `ARTO_OFF_CTRL:
          rdb = {s_r.fh, s_r.fl, s_r.len, s_r.cen,
                 s_r.split, s_r.run, s_r.xclk};
        `ARTO_OFF_CNT_LO: rdb = s_r.cnt_lo;
        `ARTO_OFF_CNT_HI: rdb = s_r.cnt_hi;
        `ARTO_OFF_RL_LO: rdb = s_r.rl_lo;
        `ARTO_OFF_RL_HI: rdb = s_r.rl_hi;
        `ARTO_OFF_AUX:
        begin
          rdb = `ARTO_BYTE_RST;
          rdb[`ARTO_AUX_IE] = s_r.ie;
          rdb[`ARTO_AUX_SYSH] = s_r.sysh;
          rdb[`ARTO_AUX_SYSL] = s_r.sysl;
          rdb[`ARTO_AUX_LFO1] = s_r.lfo_div1;
        end
        `ARTO_OFF_STAT:
        begin
          rdb = `ARTO_BYTE_RST;
          rdb[`ARTO_STAT_SYNC] = s_r.sync_pend;
          rdb[`ARTO_STAT_SUSP] = s_r.susp_d;
        end
        default: hit = 1'b0;
      endcase
      s_nxt.pslverr = ~hit;
      s_nxt.prdata = rd ? {24'h000000, rdb} : 32'h00000000;
    end
    else
    begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h00000000;
    end

    // a write to a count byte wins over a tick in the same cycle
    if (wr)
    begin
      unique case (paddr)
        `ARTO_OFF_CTRL:
        begin
          s_nxt.fh = pwdata[`ARTO_CTRL_FH];
          s_nxt.fl = pwdata[`ARTO_CTRL_FL];
          s_nxt.len = pwdata[`ARTO_CTRL_LEN];
          s_nxt.cen = pwdata[`ARTO_CTRL_CEN];
          s_nxt.split = pwdata[`ARTO_CTRL_SPLIT];
          s_nxt.run = pwdata[`ARTO_CTRL_RUN];
          s_nxt.xclk = pwdata[`ARTO_CTRL_XCLK_HI:`ARTO_CTRL_XCLK_LO];
        end
        `ARTO_OFF_CNT_LO: s_nxt.cnt_lo = pwdata[7:0];
        `ARTO_OFF_CNT_HI: s_nxt.cnt_hi = pwdata[7:0];
        `ARTO_OFF_RL_LO: s_nxt.rl_lo = pwdata[7:0];
        `ARTO_OFF_RL_HI: s_nxt.rl_hi = pwdata[7:0];
        `ARTO_OFF_AUX:
        begin
          s_nxt.ie = pwdata[`ARTO_AUX_IE];
          s_nxt.sysh = pwdata[`ARTO_AUX_SYSH];
          s_nxt.sysl = pwdata[`ARTO_AUX_SYSL];
          s_nxt.lfo_div1 = pwdata[`ARTO_AUX_LFO1];
        end
        default: ;
      endcase
    end

    // capture follows the write so a measurement is never lost
    if (s_r.cen && tk.lfo_fall)
    begin
      s_nxt.rl_lo = s_r.cnt_lo;
      s_nxt.rl_hi = s_r.cnt_hi;
      set_fh = 1'b1;
    end

    // hardware sets beat a software clear; nothing here clears a flag
    if (set_fh)
      s_nxt.fh = 1'b1;
    if (set_fl)
      s_nxt.fl = 1'b1;

    // request is a level that follows the sticky fh flag, and fl only while len is set
    s_nxt.irq = s_nxt.ie & (s_nxt.fh | (s_nxt.len & s_nxt.fl));

    // wake and sync-pending tracking
    s_nxt.susp_d = suspend;
    s_nxt.wake = 1'b0;
    if (suspend && ovf)
    begin
      s_nxt.wake = 1'b1;
      s_nxt.woke = 1'b1;
    end
    if (s_r.susp_d && !suspend)
    begin
      s_nxt.woke = 1'b0;
      if (!s_r.woke)
      begin
        s_nxt.sync_pend = 1'b1;
        s_nxt.sync_cnt = 2'h0;
      end
    end
    else if (s_r.sync_pend && tick_lo)
    begin
      if (s_r.sync_cnt == `ARTO_SYNC_LAST)
        s_nxt.sync_pend = 1'b0;
      else
        s_nxt.sync_cnt = s_r.sync_cnt + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq_req = s_r.irq;
  assign wake_req = s_r.wake;
  assign sync_pending_status = s_r.sync_pend;
endmodule // arto_timer

//--- arto_timer_monitor.sv
// port-level checker of the auto-reload timer
`timescale 1ns/1ps
module arto_timer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic suspend,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic sync_pending_status
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans)
    else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one)
    else $error("ready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside answer");
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits set");
  property p_wake; wake_req |-> $past(suspend) ##1 !wake_req; endproperty
  a_wake: assert property (p_wake)
    else $error("wake outside suspend or too long");
  property p_flag; $fell(irq_req) |-> $past(pwrite && penable && pready);
  endproperty
  a_flag: assert property (p_flag)
    else $error("request dropped without software write");
  property p_sync;
    $rose(sync_pending_status) |->
      !suspend && ($past(suspend) || $past(suspend, 2) || $past(suspend, 3));
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync pending without leaving suspend");
  c_wake: cover property (wake_req);
  c_irq: cover property ($rose(irq_req));
  c_err: cover property (pslverr);
  c_sync: cover property ($rose(sync_pending_status));
endmodule // arto_timer_monitor

//--- arto_osc_model.sv
// free-running external and low-frequency oscillator clocks
`timescale 1ns/1ps
module arto_osc_model #(
  parameter int EXT_HALF = 20,
  parameter int LFO_HALF = 44
) (
  output logic ext_osc_clk,
  output logic low_freq_oscillator
);
  // odd start offsets keep both oscillators out of phase with pclk
  initial
  begin
    ext_osc_clk = 1'b0;
    #3;
    forever #(EXT_HALF) ext_osc_clk = ~ext_osc_clk;
  end
  // lfo kept well below the timer clock so captures resolve it
  initial
  begin
    low_freq_oscillator = 1'b1;
    #5;
    forever #(LFO_HALF) low_freq_oscillator = ~low_freq_oscillator;
  end
endmodule // arto_osc_model

//--- arto_timer_test.sv
// self-checking bench of the auto-reload timer
`timescale 1ns/1ps
`include "arto_map.svh"
module arto_timer_test;
  logic pclk, presetn, psel, penable, pwrite, suspend, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdat;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, irq_req, wake_req, sync_pending_status;
  wire logic ext_osc_clk, low_freq_oscillator;
  int n_errors = 0;
  int num_checks = 0;
  arto_timer #(.SYS_DIV(`ARTO_DIV_SYS), .OSC_DIV(`ARTO_DIV_OSC)) arto_timer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_osc_clk(ext_osc_clk),
    .low_freq_oscillator(low_freq_oscillator), .suspend(suspend),
    .irq_req(irq_req), .wake_req(wake_req),
    .sync_pending_status(sync_pending_status));
  arto_osc_model arto_osc_model_i (.ext_osc_clk(ext_osc_clk),
    .low_freq_oscillator(low_freq_oscillator));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [7:0] aux, input logic [7:0] hi,
                     input logic [7:0] lo, input logic [7:0] ctrl);
    xfer(1'b1, `ARTO_OFF_AUX, aux);
    xfer(1'b1, `ARTO_OFF_CNT_HI, hi);
    xfer(1'b1, `ARTO_OFF_CNT_LO, lo);
    xfer(1'b1, `ARTO_OFF_CTRL, ctrl);
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq_req !== 1'b1; i++) @(posedge pclk);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b0, 8'(i * 4), 8'h00);
      chk(rdat, 32'h0);
      chk({31'h0, rerr}, {31'h0, i == 7});
    end
    $display("t_regs done");
  endtask
  task automatic t_clk;
    int per [4] = '{12, 40, 0, 88};
    for (int c = 0; c < 4; c++)
    begin
      cfg(8'h08, 8'h00, 8'h00, 8'(4 + c));
      repeat (per[c] == 0 ? 240 : 20 * per[c]) @(posedge pclk);
      xfer(1'b1, `ARTO_OFF_CTRL, 8'(c));
      xfer(1'b0, `ARTO_OFF_CNT_LO, 8'h00);
      if (per[c] == 0) chk(rdat, 32'h0);
      else chk({31'h0, rdat >= 18 && rdat <= 22}, 32'h1);
    end
    // oscillator/8 without the divider-is-one setting must stay still
    cfg(8'h00, 8'h00, 8'h00, 8'h07);
    repeat (240) @(posedge pclk);
    xfer(1'b0, `ARTO_OFF_CNT_LO, 8'h00);
    chk(rdat, 32'h0);
    $display("t_clk done");
  endtask
  task automatic t_16;
    xfer(1'b1, `ARTO_OFF_RL_LO, 8'h34);
    xfer(1'b1, `ARTO_OFF_RL_HI, 8'h12);
    cfg(8'h05, 8'hff, 8'hf0, 8'h04);
    wait_irq(60);
    repeat (20) @(posedge pclk);
    chk({31'h0, irq_req}, 32'h1);
    xfer(1'b0, `ARTO_OFF_CTRL, 8'h00);
    chk(rdat, 32'h0c4);
    xfer(1'b1, `ARTO_OFF_CTRL, 8'hc0);
    xfer(1'b0, `ARTO_OFF_CTRL, 8'h00);
    chk(rdat, 32'h0c0);
    xfer(1'b0, `ARTO_OFF_CNT_HI, 8'h00);
    chk(rdat, 32'h12);
    cfg(8'h05, 8'h00, 8'hf0, 8'h24);
    wait_irq(60);
    chk({31'h0, irq_req}, 32'h1);
    xfer(1'b0, `ARTO_OFF_CTRL, 8'h00);
    chk(rdat, 32'h064);
    xfer(1'b1, `ARTO_OFF_CTRL, 8'h60);
    xfer(1'b0, `ARTO_OFF_CTRL, 8'h00);
    chk(rdat, 32'h060);
    xfer(1'b1, `ARTO_OFF_CTRL, 8'h20);
    chk({31'h0, irq_req}, 32'h0);
    $display("t_16 done");
  endtask
  task automatic t_split;
    xfer(1'b1, `ARTO_OFF_RL_LO, 8'ha0);
    cfg(8'h05, 8'h77, 8'hf8, 8'h08);
    repeat (30) @(posedge pclk);
    chk({31'h0, irq_req}, 32'h0);
    xfer(1'b0, `ARTO_OFF_CTRL, 8'h00);
    chk(rdat, 32'h48);
    xfer(1'b0, `ARTO_OFF_CNT_HI, 8'h00);
    chk(rdat, 32'h77);
    xfer(1'b0, `ARTO_OFF_CNT_LO, 8'h00);
    chk({31'h0, rdat >= 32'ha0}, 32'h1);
    xfer(1'b1, `ARTO_OFF_CTRL, 8'h68);
    chk({31'h0, irq_req}, 32'h1);
    xfer(1'b1, `ARTO_OFF_RL_HI, 8'h55);
    cfg(8'h07, 8'hf0, 8'h00, 8'h0c);
    wait_irq(60);
    chk({31'h0, irq_req}, 32'h1);
    xfer(1'b0, `ARTO_OFF_CTRL, 8'h00);
    chk(rdat, 32'h08c);
    xfer(1'b1, `ARTO_OFF_CTRL, 8'h08);
    xfer(1'b0, `ARTO_OFF_CNT_HI, 8'h00);
    chk({31'h0, rdat >= 32'h55 && rdat < 32'h80}, 32'h1);
    $display("t_split done");
  endtask
  task automatic t_cap;
    cfg(8'h05, 8'h00, 8'h00, 8'h14);
    wait_irq(300);
    chk({31'h0, irq_req}, 32'h1);
    xfer(1'b0, `ARTO_OFF_CTRL, 8'h00);
    chk(rdat, 32'h094);
    xfer(1'b1, `ARTO_OFF_CTRL, 8'h00);
    chk({31'h0, irq_req}, 32'h0);
    xfer(1'b0, `ARTO_OFF_RL_LO, 8'h00);
    chk({31'h0, rdat != 32'h0 && rdat < 32'h40}, 32'h1);
    xfer(1'b0, `ARTO_OFF_RL_HI, 8'h00);
    chk(rdat, 32'h0);
    $display("t_cap done");
  endtask
  task automatic t_susp;
    cfg(8'h05, 8'hff, 8'hf0, 8'h04);
    suspend <= 1'b1;
    for (int i = 0; i < 60 && wake_req !== 1'b1; i++) @(posedge pclk);
    chk({31'h0, wake_req}, 32'h1);
    suspend <= 1'b0;
    cfg(8'h05, 8'h00, 8'h00, 8'h04);
    suspend <= 1'b1;
    repeat (5) @(posedge pclk);
    suspend <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, sync_pending_status}, 32'h1);
    repeat (8) @(posedge pclk);
    chk({31'h0, sync_pending_status}, 32'h0);
    xfer(1'b1, `ARTO_OFF_CTRL, 8'h00);
    $display("t_susp done");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    conclude();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, suspend} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_clk();
    t_16();
    t_split();
    t_cap();
    t_susp();
    conclude();
  end
endmodule // arto_timer_test
bind arto_timer arto_timer_monitor arto_timer_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .suspend(suspend), .irq_req(irq_req), .wake_req(wake_req),
  .sync_pending_status(sync_pending_status));
